/* oag_core.sv */
// Purpose: fetches operand bytes and pointers, forms effective address and length
// Assumes: memory answers a held request with a one-cycle mem_ack and data
// Notes:   one instruction at a time; start is ignored while busy
`timescale 1ns/1ns
module oag_core
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire logic         [7:0]  opcode,
  input  wire logic         [15:0] opcode_pc,
  input  wire logic                prebyte_valid,
  input  wire logic         [7:0]  prebyte,
  input  wire logic                indirect_sel,
  input  wire logic         [7:0]  index_x,
  input  wire logic         [7:0]  index_y,
  output logic                     busy,
  output logic                     mem_req,
  output logic              [15:0] mem_addr,
  input  wire logic                mem_ack,
  input  wire logic         [7:0]  mem_rdata,
  output logic                     done,
  output oag_pkg::oag_result_s     result
);

  oag_pkg::oag_state_e state;
  oag_pkg::oag_mode_e  mode;
  oag_pkg::oag_mode_e  dec_mode;
  logic [15:0]         pc_q;
  logic [7:0]          idx_q;
  logic                pre_q;
  logic [7:0]          byte0;
  logic [7:0]          byte1;
  logic [7:0]          ptr0;
  logic [7:0]          ptr1;
  logic [1:0]          opnd_cnt;
  logic [1:0]          ptr_cnt;

  oag_mode_decode u_decode
  (
    .opcode       (opcode),
    .indirect_sel (indirect_sel),
    .mode         (dec_mode)
  );

  wire logic        accept     = start && (state == oag_pkg::ST_IDLE);
  wire logic        use_y      = prebyte_valid && (prebyte == oag_pkg::SECOND_INDEX_PREBYTE);
  wire logic [1:0]  dec_opnd   = oag_pkg::operand_bytes(dec_mode);
  wire logic [1:0]  opnd_total = oag_pkg::operand_bytes(mode);
  wire logic [1:0]  ptr_total  = oag_pkg::pointer_bytes(mode);
  wire logic        opnd_last  = mem_ack && (opnd_cnt + 2'h1 == opnd_total);
  wire logic        ptr_last   = mem_ack && (ptr_cnt + 2'h1 == ptr_total);
  wire logic [7:0]  ptr_loc    = (opnd_cnt == 2'h0) ? mem_rdata : byte0;

  // length: prebyte, opcode and operand bytes
  wire logic [2:0]  len_w      = oag_pkg::OPCODE_LEN + {2'h0, pre_q} + {1'b0, opnd_total}; // RULE19
  wire logic [15:0] next_pc_w  = pc_q + {13'h0000, len_w};                               // RULE14

  wire logic [15:0] index16    = {8'h00, idx_q};
  wire logic [15:0] dir_byte   = {oag_pkg::PAGE_ZERO_HI, byte0};  // RULE2
  wire logic [15:0] dir_word   = {byte0, byte1};                  // RULE18
  wire logic [15:0] ptr_byte   = {oag_pkg::PAGE_ZERO_HI, ptr0};
  wire logic [15:0] ptr_word   = {ptr0, ptr1};                    // RULE18

  // every source is an argument, so the assigns below follow each byte as it lands
  function automatic logic [15:0] ea_select(input oag_pkg::oag_mode_e m,
                                            input logic [15:0]     db,
                                            input logic [15:0]     dw,
                                            input logic [15:0]     pb,
                                            input logic [15:0]     pw,
                                            input logic [15:0]     ix);
    unique case (m)
      oag_pkg::M_DIR_SHORT:       ea_select = db;                   // RULE6
      oag_pkg::M_DIR_LONG:        ea_select = dw;                   // RULE7
      oag_pkg::M_IDX_NONE:        ea_select = ix;                   // RULE9
      oag_pkg::M_IDX_SHORT:       ea_select = db + ix;              // RULE8 RULE10
      oag_pkg::M_IDX_LONG:        ea_select = dw + ix;              // RULE11
      oag_pkg::M_IND_SHORT:       ea_select = pb;                   // RULE12
      oag_pkg::M_IND_LONG:        ea_select = pw;                   // RULE13
      oag_pkg::M_INDIDX_SHORT:    ea_select = pb + ix;              // RULE16
      oag_pkg::M_INDIDX_LONG:     ea_select = pw + ix;
      oag_pkg::M_BIT_DIRECT,
      oag_pkg::M_BITREL_DIRECT:   ea_select = db;
      oag_pkg::M_BIT_INDIRECT,
      oag_pkg::M_BITREL_INDIRECT: ea_select = pb;
      default:                    ea_select = oag_pkg::RESET_ADDR;
    endcase
  endfunction

  function automatic logic [7:0] disp_select(input oag_pkg::oag_mode_e m,
                                             input logic [7:0]      b0,
                                             input logic [7:0]      b1,
                                             input logic [7:0]      p0);
    unique case (m)
      oag_pkg::M_REL_DIRECT:      disp_select = b0;
      oag_pkg::M_REL_INDIRECT:    disp_select = p0;                 // RULE15
      oag_pkg::M_BITREL_DIRECT,
      oag_pkg::M_BITREL_INDIRECT: disp_select = b1;
      default:                    disp_select = 8'h00;
    endcase
  endfunction

  wire logic [15:0] ea_w     = ea_select(mode, dir_byte, dir_word, ptr_byte, ptr_word, index16);
  wire logic [7:0]  disp_w   = disp_select(mode, byte0, byte1, ptr0);
  wire logic [15:0] target_w = next_pc_w + {{8{disp_w[7]}}, disp_w};  // RULE14 RULE15

  wire oag_pkg::oag_result_s next_result = '{
    mode:    mode,
    len:     len_w,
    ea:      ea_w,
    imm:     byte0,                                                 // RULE5
    next_pc: next_pc_w,
    target:  target_w
  };

  // sequencer
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state <= oag_pkg::ST_IDLE;
    else
      unique case (state)
        oag_pkg::ST_IDLE:
          if (accept)
            state <= (dec_opnd == 2'h0) ? oag_pkg::ST_CALC : oag_pkg::ST_OPND;  // RULE4
        oag_pkg::ST_OPND:
          if (opnd_last)
            state <= (ptr_total == 2'h0) ? oag_pkg::ST_CALC : oag_pkg::ST_PTR;
        oag_pkg::ST_PTR:
          if (ptr_last)
            state <= oag_pkg::ST_CALC;
        oag_pkg::ST_CALC:
          state <= oag_pkg::ST_IDLE;
      endcase
  end

  // memory request and address
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      mem_req  <= 1'b0;
      mem_addr <= oag_pkg::RESET_ADDR;
    end
    else if (accept)
    begin
      mem_req  <= (dec_opnd != 2'h0);
      mem_addr <= opcode_pc + oag_pkg::NEXT_BYTE;                   // RULE19
    end
    else if (state == oag_pkg::ST_OPND && mem_ack)
    begin
      mem_req  <= !opnd_last || (ptr_total != 2'h0);
      mem_addr <= opnd_last ? {oag_pkg::PAGE_ZERO_HI, ptr_loc}      // RULE2 RULE12 RULE13
                            : mem_addr + oag_pkg::NEXT_BYTE;
    end
    else if (state == oag_pkg::ST_PTR && mem_ack)
    begin
      mem_req  <= !ptr_last;
      mem_addr <= mem_addr + oag_pkg::NEXT_BYTE;                    // RULE18
    end
  end

  // instruction context latched on accept
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      mode  <= oag_pkg::M_INHERENT;
      pc_q  <= oag_pkg::RESET_ADDR;
      idx_q <= 8'h00;
      pre_q <= 1'b0;
    end
    else if (accept)
    begin
      mode  <= dec_mode;                                            // RULE1
      pc_q  <= opcode_pc;
      idx_q <= use_y ? index_y : index_x;                           // RULE17
      pre_q <= prebyte_valid || indirect_sel;                       // RULE19
    end
  end

  // operand and pointer bytes, high byte first
  always_ff @(posedge core_clk)
  begin
    if (!nrst || accept)
    begin
      byte0    <= 8'h00;
      byte1    <= 8'h00;
      ptr0     <= 8'h00;
      ptr1     <= 8'h00;
      opnd_cnt <= 2'h0;
      ptr_cnt  <= 2'h0;
    end
    else if (state == oag_pkg::ST_OPND && mem_ack)
    begin
      opnd_cnt <= opnd_cnt + 2'h1;
      if (opnd_cnt == 2'h0)
        byte0 <= mem_rdata;
      else
        byte1 <= mem_rdata;                                         // RULE18
    end
    else if (state == oag_pkg::ST_PTR && mem_ack)
    begin
      ptr_cnt <= ptr_cnt + 2'h1;
      if (ptr_cnt == 2'h0)
        ptr0 <= mem_rdata;
      else
        ptr1 <= mem_rdata;                                          // RULE18
    end
  end

  // result and status outputs
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= '0;
    end
    else
    begin
      busy <= accept || (busy && state != oag_pkg::ST_CALC);
      done <= (state == oag_pkg::ST_CALC);
      if (state == oag_pkg::ST_CALC)
        result <= next_result;                                      // RULE19
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  inherent_no_fetch_a: assert property (                            // RULE4
    accept && dec_mode == oag_pkg::M_INHERENT |=> !mem_req ##1 (done && !mem_req))
    else $error("inherent opcode fetched an operand");

  immediate_len_a: assert property (                                // RULE5
    done && result.mode == oag_pkg::M_IMMEDIATE
      |-> result.len == 3'h2 + {2'h0, pre_q})
    else $error("immediate length wrong");

  short_dir_page_a: assert property (                               // RULE6
    done && result.mode == oag_pkg::M_DIR_SHORT |-> result.ea[15:8] == 8'h00)
    else $error("short direct left page zero");

  short_idx_range_a: assert property (                              // RULE10
    done && (result.mode == oag_pkg::M_IDX_SHORT || result.mode == oag_pkg::M_INDIDX_SHORT)
      |-> result.ea <= 16'h01fe)
    else $error("short indexed out of range");

  rmw_short_only_a: assert property (                               // RULE3
    accept && (opcode[7:4] == oag_pkg::NIB_RMW_DIR || opcode[7:4] == oag_pkg::NIB_RMW_IDX1)
      |-> dec_mode inside {oag_pkg::M_DIR_SHORT, oag_pkg::M_IND_SHORT,
                           oag_pkg::M_IDX_SHORT, oag_pkg::M_INDIDX_SHORT})
    else $error("memory-to-memory opcode took a long form");

  rel_target_a: assert property (                                   // RULE14
    done && result.mode == oag_pkg::M_REL_DIRECT
      |-> result.target == result.next_pc + {{8{result.imm[7]}}, result.imm})
    else $error("relative target wrong");

  first_fetch_a: assert property (                                  // RULE19
    accept && dec_opnd != 2'h0 |=> mem_req && mem_addr == $past(opcode_pc) + 16'h0001)
    else $error("operand fetch not at opcode plus one");

  ptr_page_zero_a: assert property (                                // RULE2
    state == oag_pkg::ST_PTR && ptr_cnt == 2'h0 |-> mem_addr[15:8] == 8'h00)
    else $error("pointer read outside page zero");

  ptr_consec_a: assert property (                                   // RULE18
    state == oag_pkg::ST_PTR && mem_ack && ptr_cnt == 2'h0 && ptr_total == 2'h2
      |=> mem_req && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("pointer word not consecutive");

  second_index_a: assert property (                                 // RULE17
    accept && use_y |=> idx_q == $past(index_y))
    else $error("second index prebyte ignored");

  idx_none_fetch_a: assert property (                               // RULE9
    accept && dec_mode == oag_pkg::M_IDX_NONE
      |=> !mem_req ##1 (done && result.ea[15:8] == 8'h00))
    else $error("no-offset indexed fetched an operand");

  opnd_addr_step_a: assert property (                               // RULE7
    state == oag_pkg::ST_OPND && mem_ack && !opnd_last
      |=> mem_req && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("operand bytes not consecutive");

  req_hold_a: assert property (                                     // RULE18
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before acknowledge");

  done_idle_a: assert property (                                    // RULE19
    done |-> !busy)
    else $error("busy still high with result");

  cover_inherent_c: cover property (accept && dec_mode == oag_pkg::M_INHERENT ##2 done);
  cover_second_idx_c: cover property (accept && use_y ##2 done);
  cover_long_ind_c: cover property (done && result.mode == oag_pkg::M_INDIDX_LONG);
  cover_bitrel_c:   cover property (done && result.mode == oag_pkg::M_BITREL_INDIRECT);
  cover_back_rel_c: cover property (done && result.mode == oag_pkg::M_REL_DIRECT && result.imm[7]);

endmodule

/* oag_pkg.sv */
// Purpose: shared types, constants and decode helpers of the operand address generator
// Assumes: one opcode at a time, index registers held stable by the core while busy
// Notes:   opcode families below are the encoding this core uses
//
// How it works
// RULE1: seventeen modes grouped into seven families
// RULE2: short forms reach page zero only; here M_IDX_SHORT and M_INDIDX_SHORT reach up to 1fe
// RULE3: memory-to-memory opcodes decode short forms only; here NIB_RMW_IDX0 decodes to M_IDX_NONE
// RULE4: inherent is one byte, no operand fetch
// RULE5: immediate is opcode plus one value byte
// RULE6: short direct fetches one page-zero address byte
// RULE7: long direct fetches a two-byte address
// RULE8: indexed address is index plus offset, unsigned
// RULE9: no-offset indexed uses index alone
// RULE10: short indexed reaches 00 through 1fe
// RULE11: long indexed adds index to word offset
// RULE12: short indirect reads one pointer byte
// RULE13: long indirect reads a pointer word
// RULE14: branch base is the next instruction address
// RULE15: branch adds signed eight-bit displacement
// RULE16: short indirect indexed adds index to pointer
// RULE17: prebyte 90 swaps first index for second
// RULE18: words high byte first, consecutive locations
// RULE19: length counts prebyte, opcode and operands
package oag_pkg;

  localparam logic [7:0]  PAGE_ZERO_HI         = 8'h00;
  localparam logic [7:0]  SECOND_INDEX_PREBYTE = 8'h90;
  localparam logic [15:0] RESET_ADDR           = 16'h0000;
  localparam logic [15:0] NEXT_BYTE            = 16'h0001;
  localparam logic [2:0]  OPCODE_LEN           = 3'h1;

  // opcode high nibble families
  localparam logic [3:0] NIB_BIT_REL   = 4'h0;
  localparam logic [3:0] NIB_BIT       = 4'h1;
  localparam logic [3:0] NIB_REL       = 4'h2;
  localparam logic [3:0] NIB_RMW_DIR   = 4'h3;
  localparam logic [3:0] NIB_RMW_IDX1  = 4'h6;
  localparam logic [3:0] NIB_RMW_IDX0  = 4'h7;
  localparam logic [3:0] NIB_IMM       = 4'ha;
  localparam logic [3:0] NIB_DIR_SHORT = 4'hb;
  localparam logic [3:0] NIB_DIR_LONG  = 4'hc;
  localparam logic [3:0] NIB_IDX_LONG  = 4'hd;
  localparam logic [3:0] NIB_IDX_SHORT = 4'he;
  localparam logic [3:0] NIB_IDX_NONE  = 4'hf;

  typedef enum logic [4:0] {
    M_INHERENT, M_IMMEDIATE,
    M_DIR_SHORT, M_DIR_LONG,
    M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG,
    M_IND_SHORT, M_IND_LONG,
    M_INDIDX_SHORT, M_INDIDX_LONG,
    M_REL_DIRECT, M_REL_INDIRECT,
    M_BIT_DIRECT, M_BIT_INDIRECT,
    M_BITREL_DIRECT, M_BITREL_INDIRECT
  } oag_mode_e;

  typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_PTR, ST_CALC} oag_state_e;

  typedef struct packed {
    oag_mode_e   mode;
    logic [2:0]  len;
    logic [15:0] ea;
    logic [7:0]  imm;
    logic [15:0] next_pc;
    logic [15:0] target;
  } oag_result_s;

  // bytes that follow the opcode
  function automatic logic [1:0] operand_bytes(input oag_mode_e m);
    unique case (m)
      M_INHERENT, M_IDX_NONE:                  operand_bytes = 2'h0;
      M_DIR_LONG, M_IDX_LONG,
      M_BITREL_DIRECT, M_BITREL_INDIRECT:      operand_bytes = 2'h2;
      default:                                 operand_bytes = 2'h1;
    endcase
  endfunction

  // pointer bytes read from page zero
  function automatic logic [1:0] pointer_bytes(input oag_mode_e m);
    unique case (m)
      M_IND_LONG, M_INDIDX_LONG:               pointer_bytes = 2'h2;
      M_IND_SHORT, M_INDIDX_SHORT, M_REL_INDIRECT,
      M_BIT_INDIRECT, M_BITREL_INDIRECT:       pointer_bytes = 2'h1;
      default:                                 pointer_bytes = 2'h0;
    endcase
  endfunction

endpackage

/* oag_mode_decode.sv */
// Purpose: maps an opcode and the indirect select onto one addressing mode
// Assumes: indirect_sel is the core's indirect_sel input, passed through unchanged
// Notes:   purely combinational
`timescale 1ns/1ns
module oag_mode_decode
(
  input  wire logic        [7:0] opcode,
  input  wire logic              indirect_sel,
  output oag_pkg::oag_mode_e     mode
);

  wire logic [3:0] nib = opcode[7:4];

  // memory-to-memory families decode to short forms, except NIB_RMW_IDX0, which decodes to M_IDX_NONE
  wire oag_pkg::oag_mode_e short_dir = indirect_sel ? oag_pkg::M_IND_SHORT    // RULE3
                                                    : oag_pkg::M_DIR_SHORT;
  wire oag_pkg::oag_mode_e short_idx = indirect_sel ? oag_pkg::M_INDIDX_SHORT // RULE3
                                                    : oag_pkg::M_IDX_SHORT;

  always_comb
  begin
    unique case (nib)
      oag_pkg::NIB_BIT_REL:   mode = indirect_sel ? oag_pkg::M_BITREL_INDIRECT
                                                  : oag_pkg::M_BITREL_DIRECT;
      oag_pkg::NIB_BIT:       mode = indirect_sel ? oag_pkg::M_BIT_INDIRECT
                                                  : oag_pkg::M_BIT_DIRECT;
      oag_pkg::NIB_REL:       mode = indirect_sel ? oag_pkg::M_REL_INDIRECT
                                                  : oag_pkg::M_REL_DIRECT;
      oag_pkg::NIB_RMW_DIR:   mode = short_dir;
      oag_pkg::NIB_RMW_IDX1:  mode = short_idx;
      oag_pkg::NIB_RMW_IDX0:  mode = oag_pkg::M_IDX_NONE;
      oag_pkg::NIB_IMM:       mode = oag_pkg::M_IMMEDIATE;
      oag_pkg::NIB_DIR_SHORT: mode = short_dir;
      oag_pkg::NIB_DIR_LONG:  mode = indirect_sel ? oag_pkg::M_IND_LONG
                                                  : oag_pkg::M_DIR_LONG;
      oag_pkg::NIB_IDX_LONG:  mode = indirect_sel ? oag_pkg::M_INDIDX_LONG
                                                  : oag_pkg::M_IDX_LONG;
      oag_pkg::NIB_IDX_SHORT: mode = short_idx;
      oag_pkg::NIB_IDX_NONE:  mode = oag_pkg::M_IDX_NONE;
      default:                mode = oag_pkg::M_INHERENT; // RULE4
    endcase
  end

endmodule

/* oag_mem_model.sv */
// Purpose: behavioural program and data memory answering operand reads
// Assumes: one read at a time, request held until acknowledged
// Notes:   lat sets the answer delay in cycles, reads counts served reads
`timescale 1ns/1ns
module oag_mem_model
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  int         lat;
  int         waited;
  int         reads;

  initial
  begin
    lat = 0;
    reads = 0;
    waited = 0;
    last = 8'h00;
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'h5a;
  end

  // never answers an idle bus
  assign mem_ack   = mem_req && (waited >= lat);
  // released data bus shows the inverse of the last byte
  assign mem_rdata = mem_ack ? mem[mem_addr] : ~last;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      waited <= 0;
      last <= 8'h00;
    end
    else if (mem_ack)
    begin
      waited <= 0;
      last <= mem_rdata;
      reads <= reads + 1;
    end
    else if (mem_req)
      waited <= waited + 1;
  end
endmodule

/* tb.sv */
// Purpose: self-checking bench of the operand address generator
// Assumes: opcode at 1000, prebyte value fixed at 90
// Notes:   each scenario after s_reset loads memory, runs opcodes and judges the result
`timescale 1ns/1ns
module tb;
  logic                 core_clk;
  logic                 nrst;
  logic                 start;
  logic [7:0]           opcode;
  logic [15:0]          opcode_pc;
  logic                 prebyte_valid;
  logic [7:0]           prebyte;
  logic                 indirect_sel;
  logic [7:0]           index_x;
  logic [7:0]           index_y;
  logic                 busy;
  logic                 mem_req;
  logic [15:0]          mem_addr;
  logic                 mem_ack;
  logic [7:0]           mem_rdata;
  logic                 done;
  oag_pkg::oag_result_s result;
  int                   num_errors;
  int                   samples_checked;
  int                   cycles;

  oag_core i_dut (.core_clk(core_clk), .nrst(nrst), .start(start), .opcode(opcode),
    .opcode_pc(opcode_pc), .prebyte_valid(prebyte_valid), .prebyte(prebyte),
    .indirect_sel(indirect_sel), .index_x(index_x), .index_y(index_y), .busy(busy),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .done(done), .result(result));

  oag_mem_model i_mem (.core_clk(core_clk), .nrst(nrst), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #20 core_clk = ~core_clk;

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    i_mem.mem[a] = d;
  endtask

  task automatic ops(input logic [7:0] b1, input logic [7:0] b2);
    put(16'h1001, b1);
    put(16'h1002, b2);
  endtask

  task automatic kick(input logic [7:0] op, input logic pv, input logic ind);
    opcode = op;
    prebyte_valid = pv;
    indirect_sel = ind;
    start = 1'b1;
    @(posedge core_clk);
    #1;
    start = 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(16'(n < 60), 16'h0001);
  endtask

  task automatic run(input logic [7:0] op, input logic pv, input logic ind);
    i_mem.reads = 0;
    kick(op, pv, ind);
    wait_done();
  endtask

  task automatic expect_res(input oag_pkg::oag_mode_e m, input logic [2:0] len,
                            input logic use_ea, input logic [15:0] ea,
                            input logic [15:0] tgt, input int nrd);
    check(16'(result.mode), 16'(m));
    check(16'(result.len), 16'(len));
    if (use_ea)
      check(result.ea, ea);
    check(result.next_pc, 16'h1000 + 16'(len));
    check(result.target, tgt);
    check(16'(i_mem.reads), 16'(nrd));
  endtask

  task automatic s_reset();
    check({13'h0, busy, mem_req, done}, 16'h0000);
    check(result.ea, 16'h0000);
  endtask

  task automatic s_short_forms();
    run(8'h81, 1'b0, 1'b0);
    expect_res(oag_pkg::M_INHERENT, 3'h1, 1'b0, 16'h0, 16'h1001, 0);
    ops(8'h55, 8'h00);
    run(8'ha6, 1'b0, 1'b0);
    check(16'(result.imm), 16'h0055);
    expect_res(oag_pkg::M_IMMEDIATE, 3'h2, 1'b0, 16'h0, 16'h1002, 1);
    ops(8'hfe, 8'h00);
    run(8'hb6, 1'b0, 1'b0);
    expect_res(oag_pkg::M_DIR_SHORT, 3'h2, 1'b1, 16'h00fe, 16'h1002, 1);
    ops(8'h12, 8'h34);
    run(8'hc6, 1'b0, 1'b0);
    expect_res(oag_pkg::M_DIR_LONG, 3'h3, 1'b1, 16'h1234, 16'h1003, 2);
  endtask

  task automatic s_indexed();
    index_x = 8'hff;
    index_y = 8'h07;
    run(8'hf6, 1'b0, 1'b0);
    expect_res(oag_pkg::M_IDX_NONE, 3'h1, 1'b1, 16'h00ff, 16'h1001, 0);
    run(8'hf6, 1'b1, 1'b0);
    expect_res(oag_pkg::M_IDX_NONE, 3'h2, 1'b1, 16'h0007, 16'h1002, 0);
    ops(8'hff, 8'h00);
    run(8'he6, 1'b0, 1'b0);
    expect_res(oag_pkg::M_IDX_SHORT, 3'h2, 1'b1, 16'h01fe, 16'h1002, 1);
    index_x = 8'h20;
    ops(8'h12, 8'hf0);
    run(8'hd6, 1'b0, 1'b0);
    expect_res(oag_pkg::M_IDX_LONG, 3'h3, 1'b1, 16'h1310, 16'h1003, 2);
  endtask

  task automatic s_indirect();
    i_mem.lat = 1;
    ops(8'h40, 8'h00);
    put(16'h0040, 8'h9a);
    run(8'hb6, 1'b0, 1'b1);
    expect_res(oag_pkg::M_IND_SHORT, 3'h3, 1'b1, 16'h009a, 16'h1003, 2);
    ops(8'h50, 8'h00);
    put(16'h0050, 8'hab);
    put(16'h0051, 8'hcd);
    run(8'hc6, 1'b0, 1'b1);
    expect_res(oag_pkg::M_IND_LONG, 3'h3, 1'b1, 16'habcd, 16'h1003, 3);
    index_x = 8'hff;
    ops(8'h60, 8'h00);
    put(16'h0060, 8'hff);
    run(8'he6, 1'b0, 1'b1);
    expect_res(oag_pkg::M_INDIDX_SHORT, 3'h3, 1'b1, 16'h01fe, 16'h1003, 2);
    index_x = 8'h34;
    ops(8'h70, 8'h00);
    put(16'h0070, 8'h12);
    put(16'h0071, 8'h00);
    run(8'hd6, 1'b0, 1'b1);
    expect_res(oag_pkg::M_INDIDX_LONG, 3'h3, 1'b1, 16'h1234, 16'h1003, 3);
    i_mem.lat = 0;
  endtask

  task automatic s_branch_bit();
    ops(8'h80, 8'h00);
    run(8'h20, 1'b0, 1'b0);
    expect_res(oag_pkg::M_REL_DIRECT, 3'h2, 1'b0, 16'h0, 16'h0f82, 1);
    ops(8'h30, 8'h00);
    put(16'h0030, 8'h7f);
    run(8'h20, 1'b0, 1'b1);
    expect_res(oag_pkg::M_REL_INDIRECT, 3'h3, 1'b0, 16'h0, 16'h1082, 2);
    ops(8'h10, 8'h00);
    run(8'h10, 1'b0, 1'b0);
    expect_res(oag_pkg::M_BIT_DIRECT, 3'h2, 1'b1, 16'h0010, 16'h1002, 1);
    ops(8'h20, 8'h00);
    put(16'h0020, 8'h33);
    run(8'h10, 1'b0, 1'b1);
    expect_res(oag_pkg::M_BIT_INDIRECT, 3'h3, 1'b1, 16'h0033, 16'h1003, 2);
    ops(8'h44, 8'h05);
    run(8'h00, 1'b0, 1'b0);
    expect_res(oag_pkg::M_BITREL_DIRECT, 3'h3, 1'b1, 16'h0044, 16'h1008, 2);
    ops(8'h45, 8'hfb);
    put(16'h0045, 8'h66);
    run(8'h00, 1'b0, 1'b1);
    expect_res(oag_pkg::M_BITREL_INDIRECT, 3'h4, 1'b1, 16'h0066, 16'h0fff, 3);
  endtask

  task automatic s_rmw();
    ops(8'h80, 8'h00);
    run(8'h3a, 1'b0, 1'b0);
    expect_res(oag_pkg::M_DIR_SHORT, 3'h2, 1'b1, 16'h0080, 16'h1002, 1);
    index_x = 8'h11;
    ops(8'hf0, 8'h00);
    run(8'h6c, 1'b0, 1'b0);
    expect_res(oag_pkg::M_IDX_SHORT, 3'h2, 1'b1, 16'h0101, 16'h1002, 1);
    run(8'h7c, 1'b0, 1'b0);
    expect_res(oag_pkg::M_IDX_NONE, 3'h1, 1'b1, 16'h0011, 16'h1001, 0);
  endtask

  task automatic s_refuse_reset();
    i_mem.lat = 3;
    index_x = 8'h01;
    ops(8'h12, 8'hf0);
    i_mem.reads = 0;
    kick(8'hd6, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    check(16'(busy), 16'h0001);
    // a second request while busy must be dropped
    kick(8'h81, 1'b0, 1'b0);
    wait_done();
    expect_res(oag_pkg::M_IDX_LONG, 3'h3, 1'b1, 16'h12f1, 16'h1003, 2);
    repeat (4)
    begin
      @(posedge core_clk);
      #1;
      check({15'h0, done | busy}, 16'h0000);
    end
    kick(8'hd6, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    #1;
    nrst = 1'b0;
    @(posedge core_clk);
    #1;
    check({13'h0, busy, mem_req, done}, 16'h0000);
    nrst = 1'b1;
    i_mem.lat = 0;
    run(8'h81, 1'b0, 1'b0);
    expect_res(oag_pkg::M_INHERENT, 3'h1, 1'b0, 16'h0, 16'h1001, 0);
  endtask

  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    opcode_pc = 16'h1000;
    prebyte_valid = 1'b0;
    prebyte = oag_pkg::SECOND_INDEX_PREBYTE;
    indirect_sel = 1'b0;
    index_x = 8'h00;
    index_y = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    s_reset();
    s_short_forms();
    s_indexed();
    s_indirect();
    s_branch_bit();
    s_rmw();
    s_refuse_reset();
    end_of_test();
  end
endmodule
